// *** src/dtx_consts.svh ***
// Constants for the data transfer execution block.
`ifndef DTX_CONSTS_SVH
`define DTX_CONSTS_SVH
`define DTX_DATA_W     8
`define DTX_PROG_W     16
`define DTX_PC_W       16
`define DTX_FLAG_Z     0
`define DTX_FLAG_C     1
`define DTX_FLAG_AC    2
`define DTX_FLAG_OV    3
`define DTX_FLAGS_RST  4'h0
`define DTX_WORK_RST   8'h00
`define DTX_PC_RST     16'h0000
`define DTX_HI_MSB     15
`define DTX_HI_LSB     8
`define DTX_OP_NONE    4'h0
`define DTX_OP_MOVAI   4'h1
`define DTX_OP_MOVMA   4'h2
`define DTX_OP_MOVAM   4'h3
`define DTX_OP_MOVAIO  4'h4
`define DTX_OP_MOVIOA  4'h5
`define DTX_OP_NMOVMA  4'h6
`define DTX_OP_NMOVAM  4'h7
`define DTX_OP_LDTABH  4'h8
`define DTX_OP_ADD     4'h9
`define DTX_OP_SUB     4'hA
`endif

// *** src/dtx_exec.sv ***
// Execution core for the data transfer instruction group.
`include "dtx_consts.svh"

// Contract
// RULE1 - Zero flag set when updating result zero
// RULE2 - Carry on add carry or subtract borrow
// RULE3 - Half carry on carry from low nibble
// RULE4 - Overflow when signed result unrepresentable
// RULE5 - Immediate load leaves all flags untouched
// RULE6 - Store to memory leaves flags untouched
// RULE7 - Memory load updates only zero flag
// RULE8 - IO load updates only zero flag
// RULE9 - IO write leaves flags untouched
// RULE10 - Negating store writes negation, keeps flags
// RULE11 - Negating load negates, updates zero only
// RULE12 - High table load takes bits 15..8, two cycles
// RULE13 - Pointer is low and high data bytes
// RULE14 - Separate program counter per processing unit
// RULE15 - High table load leaves flags unchanged
// RULE16 - Eight-bit data, negation wraps modulo 256
module dtx_exec
  import dtx_pkg::*;
#(
  parameter int DATA_W = `DTX_DATA_W,
  parameter int PROG_W = `DTX_PROG_W,
  parameter int PC_W   = `DTX_PC_W
) (
  input  wire logic              CLOCK,
  input  wire logic              NRST,
  input  wire logic              OP_VALID,
  input  wire logic [3:0]        OP_CODE,
  input  wire logic              OP_UNIT,
  input  wire logic [DATA_W-1:0] OP_IMM,
  input  wire logic [7:0]        OP_ADDR,
  input  wire logic [DATA_W-1:0] MEM_RDATA,
  input  wire logic [DATA_W-1:0] IO_RDATA,
  input  wire logic [PROG_W-1:0] PROG_RDATA,
  input  wire logic              UNIT0_PC_LOAD,
  input  wire logic              UNIT1_PC_LOAD,
  input  wire logic [PC_W-1:0]   PC_LOAD_VALUE,
  output logic [7:0]             MEM_ADDR,
  output logic                   MEM_WE,
  output logic [DATA_W-1:0]      MEM_WDATA,
  output logic [7:0]             IO_ADDR,
  output logic                   IO_WE,
  output logic [DATA_W-1:0]      IO_WDATA,
  output logic [PC_W-1:0]        PROG_ADDR,
  output logic [DATA_W-1:0]      WORK_REGISTER,
  output logic                   ZERO_FLAG,
  output logic                   CARRY_FLAG,
  output logic                   HALF_CARRY_FLAG,
  output logic                   SIGNED_OVERFLOW_FLAG,
  output logic [PC_W-1:0]        UNIT0_PROGRAM_COUNTER,
  output logic [PC_W-1:0]        UNIT1_PROGRAM_COUNTER,
  output logic                   BUSY
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] neg8(input logic [DATA_W-1:0] v);
    neg8 = DATA_W'(~v + 1'b1); // see RULE16
  endfunction : neg8

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    is_zero = (v == '0); // see RULE1
  endfunction : is_zero

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dtx_state_e            state_r, state_nxt;
  logic [DATA_W-1:0]     work_r, work_nxt;
  logic [3:0]            flags_r, flags_nxt;
  logic [PC_W-1:0]       pc_r [2];
  logic [PC_W-1:0]       pc_nxt [2];
  logic [7:0]            mem_addr_r, mem_addr_nxt;
  logic                  mem_we_r, mem_we_nxt;
  logic [DATA_W-1:0]     mem_wdata_r, mem_wdata_nxt;
  logic [7:0]            io_addr_r, io_addr_nxt;
  logic                  io_we_r, io_we_nxt;
  logic [DATA_W-1:0]     io_wdata_r, io_wdata_nxt;
  logic [PC_W-1:0]       prog_addr_r, prog_addr_nxt;
  logic [DATA_W-1:0]     ptr_lo_r, ptr_lo_nxt;
  logic                  unit_r, unit_nxt;
  logic                  busy_r, busy_nxt;
  logic [DATA_W:0]       sum_w;
  logic [4:0]            nib_w;

  always_comb begin
    state_nxt     = state_r;
    work_nxt      = work_r;
    flags_nxt     = flags_r;
    mem_addr_nxt  = mem_addr_r;
    mem_we_nxt    = 1'b0;
    mem_wdata_nxt = mem_wdata_r;
    io_addr_nxt   = io_addr_r;
    io_we_nxt     = 1'b0;
    io_wdata_nxt  = io_wdata_r;
    prog_addr_nxt = prog_addr_r;
    ptr_lo_nxt    = ptr_lo_r;
    unit_nxt      = unit_r;
    sum_w         = '0;
    nib_w         = '0;
    for (int u = 0; u < 2; u++) begin
      pc_nxt[u] = pc_r[u];
    end
    if (UNIT0_PC_LOAD) begin
      pc_nxt[0] = PC_LOAD_VALUE; // see RULE14
    end
    if (UNIT1_PC_LOAD) begin
      pc_nxt[1] = PC_LOAD_VALUE; // see RULE14
    end
    case (state_r)
      DTX_IDLE: begin
        if (OP_VALID) begin
          // Each accepted instruction advances only its issuing unit, at issue, unless that unit's PC is loaded in the same cycle.
          if (!(OP_UNIT ? UNIT1_PC_LOAD : UNIT0_PC_LOAD)) begin
            pc_nxt[OP_UNIT] = PC_W'(pc_r[OP_UNIT] + 1'b1); // see RULE14
          end
          case (OP_CODE)
            `DTX_OP_MOVAI: begin
              work_nxt = OP_IMM; // see RULE5
            end
            `DTX_OP_MOVMA: begin
              mem_addr_nxt  = OP_ADDR;
              mem_we_nxt    = 1'b1;
              mem_wdata_nxt = work_r; // see RULE6
            end
            `DTX_OP_MOVAM: begin
              work_nxt = MEM_RDATA;
              flags_nxt[`DTX_FLAG_Z] = is_zero(MEM_RDATA); // see RULE7
            end
            `DTX_OP_MOVAIO: begin
              work_nxt = IO_RDATA;
              flags_nxt[`DTX_FLAG_Z] = is_zero(IO_RDATA); // see RULE8
            end
            `DTX_OP_MOVIOA: begin
              io_addr_nxt  = OP_ADDR;
              io_we_nxt    = 1'b1;
              io_wdata_nxt = work_r; // see RULE9
            end
            `DTX_OP_NMOVMA: begin
              mem_addr_nxt  = OP_ADDR;
              mem_we_nxt    = 1'b1;
              mem_wdata_nxt = neg8(work_r); // see RULE10
            end
            `DTX_OP_NMOVAM: begin
              work_nxt = neg8(MEM_RDATA);
              flags_nxt[`DTX_FLAG_Z] = is_zero(neg8(MEM_RDATA)); // see RULE11
            end
            `DTX_OP_LDTABH: begin
              // The pointer low byte sits at the word address, its high byte just above.
              ptr_lo_nxt   = MEM_RDATA; // see RULE13
              mem_addr_nxt = 8'(OP_ADDR + 1'b1);
              unit_nxt     = OP_UNIT;
              state_nxt    = DTX_TAB_PTR;
            end
            `DTX_OP_ADD: begin
              sum_w = {1'b0, work_r} + {1'b0, MEM_RDATA};
              nib_w = {1'b0, work_r[3:0]} + {1'b0, MEM_RDATA[3:0]};
              work_nxt = sum_w[DATA_W-1:0];
              flags_nxt[`DTX_FLAG_Z]  = is_zero(sum_w[DATA_W-1:0]); // see RULE1
              flags_nxt[`DTX_FLAG_C]  = sum_w[DATA_W]; // see RULE2
              flags_nxt[`DTX_FLAG_AC] = nib_w[4]; // see RULE3
              flags_nxt[`DTX_FLAG_OV] = (work_r[DATA_W-1] == MEM_RDATA[DATA_W-1]) &&
                  (sum_w[DATA_W-1] != work_r[DATA_W-1]); // see RULE4
            end
            `DTX_OP_SUB: begin
              sum_w = {1'b0, work_r} - {1'b0, MEM_RDATA};
              nib_w = {1'b0, work_r[3:0]} - {1'b0, MEM_RDATA[3:0]};
              work_nxt = sum_w[DATA_W-1:0];
              flags_nxt[`DTX_FLAG_Z]  = is_zero(sum_w[DATA_W-1:0]); // see RULE1
              flags_nxt[`DTX_FLAG_C]  = sum_w[DATA_W]; // see RULE2
              flags_nxt[`DTX_FLAG_AC] = nib_w[4]; // see RULE3
              flags_nxt[`DTX_FLAG_OV] = (work_r[DATA_W-1] != MEM_RDATA[DATA_W-1]) &&
                  (sum_w[DATA_W-1] != work_r[DATA_W-1]); // see RULE4
            end
            default: begin
            end
          endcase
        end
      end
      DTX_TAB_PTR: begin
        prog_addr_nxt = PC_W'({MEM_RDATA, ptr_lo_r}); // see RULE13
        state_nxt     = DTX_TAB_FETCH;
      end
      DTX_TAB_FETCH: begin
        // Flags are left alone on purpose: the table read is a pure move.
        work_nxt  = PROG_RDATA[`DTX_HI_MSB:`DTX_HI_LSB]; // see RULE12, RULE15
        state_nxt = DTX_IDLE;
      end
      default: begin
        state_nxt = DTX_IDLE;
      end
    endcase
    // Busy is registered from the next state so the port comes straight from a flop.
    busy_nxt = (state_nxt != DTX_IDLE);
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      state_r     <= DTX_IDLE;
      work_r      <= `DTX_WORK_RST;
      flags_r     <= `DTX_FLAGS_RST;
      mem_addr_r  <= 8'h00;
      mem_we_r    <= 1'b0;
      mem_wdata_r <= 8'h00;
      io_addr_r   <= 8'h00;
      io_we_r     <= 1'b0;
      io_wdata_r  <= 8'h00;
      prog_addr_r <= `DTX_PC_RST;
      ptr_lo_r    <= 8'h00;
      unit_r      <= 1'b0;
      busy_r      <= 1'b0;
      pc_r[0]     <= `DTX_PC_RST;
      pc_r[1]     <= `DTX_PC_RST;
    end else begin
      state_r     <= state_nxt;
      work_r      <= work_nxt;
      flags_r     <= flags_nxt;
      mem_addr_r  <= mem_addr_nxt;
      mem_we_r    <= mem_we_nxt;
      mem_wdata_r <= mem_wdata_nxt;
      io_addr_r   <= io_addr_nxt;
      io_we_r     <= io_we_nxt;
      io_wdata_r  <= io_wdata_nxt;
      prog_addr_r <= prog_addr_nxt;
      ptr_lo_r    <= ptr_lo_nxt;
      unit_r      <= unit_nxt;
      busy_r      <= busy_nxt;
      pc_r[0]     <= pc_nxt[0];
      pc_r[1]     <= pc_nxt[1];
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign MEM_ADDR              = mem_addr_r;
  assign MEM_WE                = mem_we_r;
  assign MEM_WDATA             = mem_wdata_r;
  assign IO_ADDR               = io_addr_r;
  assign IO_WE                 = io_we_r;
  assign IO_WDATA              = io_wdata_r;
  assign PROG_ADDR             = prog_addr_r;
  assign WORK_REGISTER         = work_r;
  assign ZERO_FLAG             = flags_r[`DTX_FLAG_Z];
  assign CARRY_FLAG            = flags_r[`DTX_FLAG_C];
  assign HALF_CARRY_FLAG       = flags_r[`DTX_FLAG_AC];
  assign SIGNED_OVERFLOW_FLAG  = flags_r[`DTX_FLAG_OV];
  assign UNIT0_PROGRAM_COUNTER = pc_r[0];
  assign UNIT1_PROGRAM_COUNTER = pc_r[1];
  // Busy covers the extra cycles of the table load; new ops are ignored then.
  assign BUSY                  = busy_r;

endmodule : dtx_exec

// *** src/dtx_pkg.sv ***
// Types shared by the data transfer execution block.
package dtx_pkg;
  typedef enum logic [1:0] {
    DTX_IDLE,
    DTX_TAB_PTR,
    DTX_TAB_FETCH
  } dtx_state_e;
  typedef logic [3:0] dtx_op_t;
endpackage : dtx_pkg

// *** test/dtx_exec_props.sv ***
// Concurrent checks on the ports of the data transfer core.
module dtx_exec_props
  import dtx_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int PROG_W = 16,
  parameter int PC_W   = 16
) (
  input wire logic              CLOCK, NRST, OP_VALID, OP_UNIT, BUSY, MEM_WE, IO_WE,
  input wire logic              UNIT0_PC_LOAD, UNIT1_PC_LOAD, ZERO_FLAG, CARRY_FLAG,
  input wire logic              HALF_CARRY_FLAG, SIGNED_OVERFLOW_FLAG,
  input wire logic [3:0]        OP_CODE,
  input wire logic [7:0]        OP_ADDR, MEM_ADDR,
  input wire logic [DATA_W-1:0] OP_IMM, MEM_RDATA, MEM_WDATA, IO_WDATA, WORK_REGISTER,
  input wire logic [PROG_W-1:0] PROG_RDATA,
  input wire logic [PC_W-1:0]   PROG_ADDR, UNIT0_PROGRAM_COUNTER, UNIT1_PROGRAM_COUNTER
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       tk;
  logic [3:0] fl;
  assign tk = OP_VALID && !BUSY;
  assign fl = {SIGNED_OVERFLOW_FLAG, HALF_CARRY_FLAG, CARRY_FLAG, ZERO_FLAG};
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);
  a_imm_load: assert property (tk && OP_CODE == 4'h1 |=>
    WORK_REGISTER == $past(OP_IMM) && $stable(fl)) else $error("Immediate load wrong.");
  a_mem_store: assert property (tk && OP_CODE == 4'h2 |=> MEM_WE &&
    MEM_ADDR == $past(OP_ADDR) && MEM_WDATA == $past(WORK_REGISTER) && $stable(fl))
    else $error("Store wrong.");
  a_mem_load: assert property (tk && OP_CODE == 4'h3 |=>
    WORK_REGISTER == $past(MEM_RDATA) && ZERO_FLAG == (WORK_REGISTER == 8'h00)
    && $stable(fl[3:1])) else $error("Memory load wrong.");
  a_io_store: assert property (tk && OP_CODE == 4'h5 |=>
    IO_WE && IO_WDATA == $past(WORK_REGISTER) && $stable(fl)) else $error("IO write wrong.");
  a_neg_store: assert property (tk && OP_CODE == 4'h6 |=> MEM_WE &&
    MEM_WDATA == 8'h00 - $past(WORK_REGISTER) && $stable(WORK_REGISTER) && $stable(fl))
    else $error("Negating store wrong.");
  a_neg_load: assert property (tk && OP_CODE == 4'h7 |=> !MEM_WE &&
    WORK_REGISTER == 8'h00 - $past(MEM_RDATA) && ZERO_FLAG == (WORK_REGISTER == 8'h00)
    && $stable(fl[3:1])) else $error("Negating load wrong.");
  a_tab_busy: assert property (tk && OP_CODE == 4'h8 |=>
    BUSY [*2] ##1 !BUSY) else $error("Table load length wrong.");
  a_tab_pointer: assert property (tk && OP_CODE == 4'h8 |=>
    MEM_ADDR == $past(OP_ADDR) + 8'h01 ##1 PROG_ADDR == {$past(MEM_RDATA), $past(MEM_RDATA, 2)})
    else $error("Table pointer wrong.");
  a_tab_result: assert property (tk && OP_CODE == 4'h8 |-> ##3
    {8'h00, WORK_REGISTER} == $past(PROG_RDATA) >> 8 && fl == $past(fl, 3))
    else $error("Table result wrong.");
  a_add_flags: assert property (tk && OP_CODE == 4'h9 |=>
    {CARRY_FLAG, WORK_REGISTER} == $past(WORK_REGISTER) + $past(MEM_RDATA) && HALF_CARRY_FLAG
    == (($past(WORK_REGISTER) & 8'h0F) + ($past(MEM_RDATA) & 8'h0F) > 8'h0F))
    else $error("Add flags wrong.");
  a_pc_step: assert property (tk && !UNIT0_PC_LOAD && !UNIT1_PC_LOAD && !OP_UNIT |=>
    UNIT0_PROGRAM_COUNTER == $past(UNIT0_PROGRAM_COUNTER) + 16'h0001
    && $stable(UNIT1_PROGRAM_COUNTER)) else $error("Program counter step wrong.");
  c_tab_load: cover property (tk && OP_CODE == 4'h8);
  c_refused: cover property (OP_VALID && BUSY);
  c_add_carry: cover property (tk && OP_CODE == 4'h9 ##1 CARRY_FLAG);
endmodule : dtx_exec_props

bind dtx_exec dtx_exec_props #(.DATA_W(DATA_W), .PROG_W(PROG_W), .PC_W(PC_W))
  i_dtx_exec_props (.*);

// *** test/dtx_partner.sv ***
// Data memory, IO space and program memory that face the core.
module dtx_partner
  import dtx_pkg::*;
(
  input  wire logic        clock, busy, mem_we, io_we,
  input  wire logic [7:0]  op_addr, mem_addr, mem_wdata, io_addr, io_wdata,
  input  wire logic [15:0] prog_addr,
  output logic      [7:0]  mem_rdata, io_rdata,
  output logic      [15:0] prog_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem[256];
  logic [7:0] io[256];
  logic [7:0] ra;
  assign ra = busy ? mem_addr : op_addr;
  // Reads see a same-cycle write, since loads may follow stores back to back.
  assign mem_rdata = (mem_we && mem_addr == ra) ? mem_wdata : mem[ra];
  assign io_rdata = (io_we && io_addr == op_addr) ? io_wdata : io[op_addr];
  // The high byte weighs both pointer bytes unevenly, so swapped bytes show up.
  assign prog_rdata = {prog_addr[7:0] + {prog_addr[14:8], 1'b0}, prog_addr[15:8]};
  always @(posedge clock) begin
    if (mem_we) mem[mem_addr] <= mem_wdata;
    if (io_we) io[io_addr] <= io_wdata;
  end
endmodule : dtx_partner

// *** test/tb_dtx_exec.sv ***
// Self-checking bench for the data transfer core.
module tb_dtx_exec import dtx_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, nrst, op_valid, op_unit, ld0, ld1, mem_we, io_we, busy, zf, cf, hf, vf;
  logic [3:0]  op_code;
  logic [7:0]  op_imm, op_addr, mem_addr, mem_wdata, io_addr, io_wdata, work, mem_rd, io_rd;
  logic [15:0] pc_val, prog_addr, prog_rd, pc0, pc1;
  logic [31:0] seed;
  int          w, z, c, h, v, p0, p1, n_mismatch, num_checks, r;
  int          m[256], io[256];
  dtx_exec i_dtx_exec (.CLOCK(clock), .NRST(nrst), .OP_VALID(op_valid), .OP_CODE(op_code),
    .OP_UNIT(op_unit), .OP_IMM(op_imm), .OP_ADDR(op_addr), .MEM_RDATA(mem_rd),
    .IO_RDATA(io_rd), .PROG_RDATA(prog_rd), .UNIT0_PC_LOAD(ld0), .UNIT1_PC_LOAD(ld1),
    .PC_LOAD_VALUE(pc_val), .MEM_ADDR(mem_addr), .MEM_WE(mem_we), .MEM_WDATA(mem_wdata),
    .IO_ADDR(io_addr), .IO_WE(io_we), .IO_WDATA(io_wdata), .PROG_ADDR(prog_addr),
    .WORK_REGISTER(work), .ZERO_FLAG(zf), .CARRY_FLAG(cf), .HALF_CARRY_FLAG(hf),
    .SIGNED_OVERFLOW_FLAG(vf), .UNIT0_PROGRAM_COUNTER(pc0), .UNIT1_PROGRAM_COUNTER(pc1),
    .BUSY(busy));
  dtx_partner i_dtx_partner (.clock(clock), .busy(busy), .mem_we(mem_we), .io_we(io_we),
    .op_addr(op_addr), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .io_addr(io_addr),
    .io_wdata(io_wdata), .prog_addr(prog_addr), .mem_rdata(mem_rd), .io_rdata(io_rd),
    .prog_rdata(prog_rd));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input string nm, input logic [31:0] seen, input int exp);
    num_checks++;
    if (seen !== 32'(exp)) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  // Called at a falling edge; leaves the next request to follow back to back.
  task automatic issue(input int op, input int a, input int imm, input int u);
    int s;
    int b;
    {op_valid, op_code, op_addr, op_imm, op_unit} = {1'b1, 4'(op), 8'(a), 8'(imm), u[0]};
    b = m[a];
    case (op)
      1: w = imm;
      2: m[a] = w;
      3: w = b;
      4: w = io[a];
      5: io[a] = w;
      6: m[a] = (256 - w) & 255;
      7: w = (256 - b) & 255;
      8: w = (b + 2 * m[a + 1]) & 255;
      default: begin
        s = (op == 9) ? w + b : w - b;
        c = (op == 9) ? s > 255 : w < b;
        h = (op == 9) ? (w & 15) + (b & 15) > 15 : (w & 15) < (b & 15);
        v = ((op == 9 ? (b ^ s) : (w ^ b)) & (w ^ s) & 128) != 0;
        w = s & 255;
      end
    endcase
    if (op inside {3, 4, 7, 9, 10}) z = (w == 0);
    if (u[0]) p1++;
    else p0++;
    if (op == 8) begin
      @(negedge clock);
      op_code = 4'h1;
      @(negedge clock);
    end
    @(negedge clock);
    chk("work", work, w);
    chk("flags", {vf, hf, cf, zf}, v * 8 + h * 4 + c * 2 + z);
    chk("pcs", {pc1, pc0}, ((p1 & 65535) << 16) | (p0 & 65535));
    chk("writes", {mem_we, io_we}, (op == 2 || op == 6) * 2 + (op == 5));
    if (op inside {2, 6}) chk("mem", {mem_addr, mem_wdata}, a * 256 + m[a]);
    if (op == 5) chk("io", {io_addr, io_wdata}, a * 256 + io[a]);
  endtask : issue
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    seed = 32'h0000A2DB;
    {nrst, op_valid, op_unit, ld0, ld1, op_code, op_imm, op_addr, pc_val} = 45'h0;
    for (int i = 0; i < 256; i++) begin
      m[i] = (i == 0) ? 0 : rnd() & 255;
      io[i] = (i == 0) ? 0 : rnd() & 255;
      i_dtx_partner.mem[i] = 8'(m[i]);
      i_dtx_partner.io[i] = 8'(io[i]);
    end
    repeat (20) @(negedge clock);
    nrst = 1'b1;
    chk("reset", {busy, vf, hf, cf, zf, work, pc0}, 0);
    r = rnd();
    {pc_val, ld0, ld1} = {r[15:0], 2'h3};
    @(negedge clock);
    {ld0, ld1, p0, p1} = {2'h0, r & 65535, r & 65535};
    for (int k = 0; k < 300; k++) begin
      r = rnd();
      issue(1 + r[3:0] % 10, r[7:4], r[16] ? r[15:8] : 0, r[20]);
    end
    op_valid = 1'b0;
    wrap_up();
  end
endmodule : tb_dtx_exec
